/* logic/thzc_pkg.sv */
// constants, field layout and decoders for the thermal zone charge registers
// assumes an 8-bit register pointer reached over a two-wire serial port
package thzc_pkg;

  // ------------------------------------------------------------------
  // serial port and register map
  // ------------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR      = 7'h3c;
  localparam logic [7:0] COOL_OFS      = 8'h15;
  localparam logic [7:0] ROOM_OFS      = 8'h16;
  localparam logic [7:0] COOL_RST      = 8'h60;
  localparam logic [7:0] ROOM_RST      = 8'h1f;
  localparam logic [7:0] COOL_MASK     = 8'h7f;
  localparam logic [7:0] ROOM_MASK     = 8'h1f;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ------------------------------------------------------------------
  // field positions and codes
  // ------------------------------------------------------------------
  localparam int         EN_LSB       = 5;
  localparam int         VOFS_LSB     = 3;
  localparam int         ISCL_LSB     = 0;
  localparam logic [1:0] EN_OFF       = 2'h0;
  localparam logic [1:0] EN_COOL_ROOM = 2'h1;
  localparam logic [1:0] EN_ROOM_WARM = 2'h2;
  localparam logic [1:0] EN_ALL       = 2'h3;
  localparam logic [2:0] ISCL_FULL    = 3'h7;
  localparam logic [3:0] FULL_TENTHS  = 4'ha;
  localparam logic [3:0] MIN_TENTHS   = 4'h2;
  localparam logic [7:0] MV_150       = 8'h96;
  localparam logic [7:0] MV_100       = 8'h64;
  localparam logic [7:0] MV_50        = 8'h32;
  localparam logic [7:0] MV_0         = 8'h00;

  // zone reported by the thermistor comparators
  localparam logic [2:0] ZONE_COLD = 3'h0;
  localparam logic [2:0] ZONE_COOL = 3'h1;
  localparam logic [2:0] ZONE_ROOM = 3'h2;
  localparam logic [2:0] ZONE_WARM = 3'h3;
  localparam logic [2:0] ZONE_HOT  = 3'h4;

  typedef enum logic [3:0] {
    st_idle, st_addr, st_aack, st_ptr, st_pack,
    st_wdat, st_wack, st_rdat, st_rack
  } thzc_i2c_state_t;

  // ------------------------------------------------------------------
  // decoders
  // ------------------------------------------------------------------
  function automatic logic [7:0] thzc_offset_mv(input logic [1:0] code);
    unique case (code)
      2'h0: thzc_offset_mv = MV_150;
      2'h1: thzc_offset_mv = MV_100;
      2'h2: thzc_offset_mv = MV_50;
      2'h3: thzc_offset_mv = MV_0;
    endcase
  endfunction

  function automatic logic [3:0] thzc_scale(input logic [2:0] code);
    if (code == ISCL_FULL) begin
      thzc_scale = FULL_TENTHS;
    end else begin
      thzc_scale = MIN_TENTHS + {1'b0, code};
    end
  endfunction

endpackage

/* logic/thzc_reg_if.sv */
// register access signals between the serial port and the register bank
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface thzc_reg_if;
  logic       wr_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       sda_drive;

  modport port (
    output wr_stb,
    output addr,
    output wdata,
    output sda_drive,
    input  rdata
  );

  modport bank (
    input  wr_stb,
    input  addr,
    input  wdata,
    input  sda_drive,
    output rdata
  );
endinterface

/* logic/thzc_i2c_port.sv */
// two-wire serial slave with an auto-incrementing register pointer
// assumes scl and sda arrive asynchronously and are oversampled by clk_in
`timescale 1ns/1ps
module thzc_i2c_port
  import thzc_pkg::*;
(
  input  wire logic  clk_in,
  input  wire logic  reset_in,
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  thzc_reg_if.port   bus
);

  // ------------------------------------------------------------------
  // synchronisers and bus conditions
  // ------------------------------------------------------------------
  logic [1:0]      scl_sync;
  logic [1:0]      sda_sync;
  logic            scl_q;
  logic            sda_q;
  thzc_i2c_state_t state;
  thzc_i2c_state_t next_state;
  logic [3:0]      cnt;
  logic [3:0]      next_cnt;
  logic [7:0]      shift;
  logic [7:0]      next_shift;
  logic [7:0]      ptr;
  logic [7:0]      next_ptr;
  logic            drive;
  logic            next_drive;
  logic            rw;
  logic            next_rw;
  logic            wr_stb;
  logic            next_wr;

  wire scl      = scl_sync[1];
  wire sda      = sda_sync[1];
  wire start    = scl & scl_q & sda_q & ~sda;
  wire stop     = scl & scl_q & ~sda_q & sda;
  wire rise     = scl & ~scl_q;
  wire fall     = ~scl & scl_q;
  wire full     = (cnt == BITS_PER_BYTE);
  wire addr_hit = (shift[7:1] == DEV_ADDR);

  assign bus.addr      = ptr;
  assign bus.wdata     = shift;
  assign bus.wr_stb    = wr_stb;
  assign bus.sda_drive = drive;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end

  // ------------------------------------------------------------------
  // transfer sequencer
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_shift = shift;
    next_ptr   = ptr;
    next_drive = drive;
    next_rw    = rw;
    next_wr    = 1'b0;
    if (start) begin
      next_state = st_addr;
      next_cnt   = 4'h0;
      next_drive = 1'b0;
    end else if (stop) begin
      next_state = st_idle;
      next_drive = 1'b0;
    end else if (rise) begin
      unique case (state)
        st_addr, st_ptr, st_wdat: if (!full) begin
          next_shift = {shift[6:0], sda};
          next_cnt   = cnt + 4'h1;
        end
        st_rdat: next_cnt = cnt + 4'h1;
        st_rack: if (sda) begin
          next_state = st_idle;
        end else begin
          next_ptr = ptr + 8'h01;
        end
        default: ;
      endcase
    end else if (fall) begin
      unique case (state)
        st_addr: if (full) begin
          next_state = addr_hit ? st_aack : st_idle;
          next_drive = addr_hit;
          next_rw    = shift[0];
        end
        st_ptr: if (full) begin
          next_ptr   = shift;
          next_drive = 1'b1;
          next_state = st_pack;
        end
        st_wdat: if (full) begin
          next_wr    = 1'b1;
          next_drive = 1'b1;
          next_state = st_wack;
        end
        st_aack, st_rack: begin
          next_cnt = 4'h0;
          if (state == st_aack && !rw) begin
            next_drive = 1'b0;
            next_state = st_ptr;
          end else begin
            next_shift = bus.rdata;
            next_drive = ~bus.rdata[7];
            next_state = st_rdat;
          end
        end
        st_pack, st_wack: begin
          next_drive = 1'b0;
          next_cnt   = 4'h0;
          next_state = st_wdat;
          if (state == st_wack) begin
            next_ptr = ptr + 8'h01;
          end
        end
        st_rdat: if (full) begin
          next_drive = 1'b0;
          next_state = st_rack;
        end else begin
          next_shift = {shift[6:0], 1'b0};
          next_drive = ~shift[6];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state  <= st_idle;
      cnt    <= 4'h0;
      shift  <= 8'h00;
      ptr    <= 8'h00;
      drive  <= 1'b0;
      rw     <= 1'b0;
      wr_stb <= 1'b0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      shift  <= next_shift;
      ptr    <= next_ptr;
      drive  <= next_drive;
      rw     <= next_rw;
      wr_stb <= next_wr;
    end
  end

endmodule

/* logic/thzc_config.sv */
// thermal zone charge configuration: two registers and their zone decode
// assumes zone_in comes from on-chip logic on clk_in; pins are asynchronous
`timescale 1ns/1ps
module thzc_config
  import thzc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       i2c_scl_in,
  input  wire logic       i2c_sda_in,
  output logic            i2c_sda_out,
  output logic            i2c_sda_oe_out,
  input  wire logic       charger_input_supply_in,
  input  wire logic       input_detect_option_in,
  input  wire logic [2:0] zone_in,
  output logic [1:0]      thermistor_zone_enable_out,
  output logic            monitor_enable_out,
  output logic            charge_permit_out,
  output logic [3:0]      current_tenths_out,
  output logic [7:0]      voltage_reduction_mv_out
);

  // ------------------------------------------------------------------
  // serial port
  // ------------------------------------------------------------------
  thzc_reg_if bus ();

  thzc_i2c_port u_port (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .scl_in   (i2c_scl_in),
    .sda_in   (i2c_sda_in),
    .bus      (bus)
  );

  // ------------------------------------------------------------------
  // supply edge detection
  // ------------------------------------------------------------------
  logic [1:0] sup_sync;
  logic [1:0] opt_sync;
  logic       sup_q;

  wire sup          = sup_sync[1];
  wire opt_rising   = opt_sync[1];
  wire supply_edge  = opt_rising ? (sup & ~sup_q) : (~sup & sup_q);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sup_sync <= 2'h0;
      opt_sync <= 2'h0;
      sup_q    <= 1'b0;
    end else begin
      sup_sync <= {sup_sync[0], charger_input_supply_in};
      opt_sync <= {opt_sync[0], input_detect_option_in};
      sup_q    <= sup_sync[1];
    end
  end

  // ------------------------------------------------------------------
  // register bank
  // ------------------------------------------------------------------
  logic [7:0] cool_cfg;
  logic [7:0] room_cfg;

  wire       cool_wr   = bus.wr_stb && (bus.addr == COOL_OFS);
  wire       room_wr   = bus.wr_stb && (bus.addr == ROOM_OFS);
  wire [7:0] next_cool = supply_edge ? COOL_RST :
                         cool_wr ? (bus.wdata & COOL_MASK) : cool_cfg;
  wire [7:0] next_room = supply_edge ? ROOM_RST :
                         room_wr ? (bus.wdata & ROOM_MASK) : room_cfg;

  assign bus.rdata = (bus.addr == COOL_OFS) ? cool_cfg :
                     (bus.addr == ROOM_OFS) ? room_cfg : UNMAPPED_DATA;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cool_cfg <= COOL_RST;
      room_cfg <= ROOM_RST;
    end else begin
      cool_cfg <= next_cool;
      room_cfg <= next_room;
    end
  end

  // ------------------------------------------------------------------
  // fields and zone decode
  // ------------------------------------------------------------------
  wire [1:0] en        = cool_cfg[EN_LSB +: 2];
  wire [1:0] cool_vofs = cool_cfg[VOFS_LSB +: 2];
  wire [2:0] cool_iscl = cool_cfg[ISCL_LSB +: 3];
  wire [1:0] room_vofs = room_cfg[VOFS_LSB +: 2];
  wire [2:0] room_iscl = room_cfg[ISCL_LSB +: 3];

  wire mon     = (en != EN_OFF);
  wire in_cool = (zone_in == ZONE_COOL);
  wire in_room = (zone_in == ZONE_ROOM);
  wire in_warm = (zone_in == ZONE_WARM);

  wire zone_ok = (in_cool & en[0]) | in_room | (in_warm & en[1]);
  wire next_permit = ~mon | zone_ok;

  wire [3:0] next_tenths = !mon    ? FULL_TENTHS :
                           in_cool ? thzc_scale(cool_iscl) :
                           in_room ? thzc_scale(room_iscl) : FULL_TENTHS;

  wire [7:0] next_mv = !mon    ? MV_0 :
                       in_cool ? thzc_offset_mv(cool_vofs) :
                       in_room ? thzc_offset_mv(room_vofs) : MV_0;

  // ------------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      i2c_sda_out                <= 1'b0;
      i2c_sda_oe_out             <= 1'b0;
      thermistor_zone_enable_out <= EN_OFF;
      monitor_enable_out         <= 1'b0;
      charge_permit_out          <= 1'b0;
      current_tenths_out         <= FULL_TENTHS;
      voltage_reduction_mv_out   <= MV_0;
    end else begin
      i2c_sda_out                <= 1'b0;
      i2c_sda_oe_out             <= bus.sda_drive;
      thermistor_zone_enable_out <= en;
      monitor_enable_out         <= mon;
      charge_permit_out          <= next_permit;
      current_tenths_out         <= next_tenths;
      voltage_reduction_mv_out   <= next_mv;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_off_permits:
    assert property (@(posedge clk_in) disable iff (reset_in)
      en == EN_OFF |=> charge_permit_out && !monitor_enable_out &&
        current_tenths_out == FULL_TENTHS)
    else $error("monitoring off must permit full charge");

  a_cool_room_warm:
    assert property (@(posedge clk_in) disable iff (reset_in)
      en == EN_COOL_ROOM && in_warm |=> !charge_permit_out)
    else $error("enable 01 must block warm zone");

  a_room_warm_cool:
    assert property (@(posedge clk_in) disable iff (reset_in)
      en == EN_ROOM_WARM && (in_cool || in_warm) |=>
        charge_permit_out == $past(in_warm))
    else $error("enable 10 must block cool and allow warm");

  a_all_zones:
    assert property (@(posedge clk_in) disable iff (reset_in)
      en == EN_ALL |=> charge_permit_out == $past(in_cool || in_room ||
        in_warm))
    else $error("enable 11 must allow cool, room and warm");

  a_edge_restores:
    assert property (@(posedge clk_in) disable iff (reset_in)
      supply_edge |=> cool_cfg == COOL_RST && room_cfg == ROOM_RST)
    else $error("supply edge must restore defaults");

  a_edge_after_sync:
    assert property (@(posedge clk_in) disable iff (reset_in)
      $rose(sup) && opt_rising && $stable(opt_rising) |-> supply_edge
        ##1 !supply_edge)
    else $error("rising supply must give one edge pulse");

  a_cool_current:
    assert property (@(posedge clk_in) disable iff (reset_in)
      mon && in_cool |=> current_tenths_out == thzc_scale($past(cool_iscl)))
    else $error("cool zone current scale wrong");

  a_room_voltage:
    assert property (@(posedge clk_in) disable iff (reset_in)
      mon && in_room |=>
        voltage_reduction_mv_out == thzc_offset_mv($past(room_vofs)))
    else $error("room zone voltage offset wrong");

  a_cool_voltage:
    assert property (@(posedge clk_in) disable iff (reset_in)
      mon && in_cool |=>
        voltage_reduction_mv_out == thzc_offset_mv($past(cool_vofs)))
    else $error("cool zone voltage offset wrong");

  a_room_current:
    assert property (@(posedge clk_in) disable iff (reset_in)
      mon && in_room && room_iscl == ISCL_FULL |=>
        current_tenths_out == FULL_TENTHS)
    else $error("room zone code 111 must give full current");

  a_room_current_min:
    assert property (@(posedge clk_in) disable iff (reset_in)
      mon && in_room && room_iscl == 3'h0 |=>
        current_tenths_out == MIN_TENTHS)
    else $error("room zone code 000 must give 0.2 current");

  a_cold_hot_block:
    assert property (@(posedge clk_in) disable iff (reset_in)
      mon && !in_cool && !in_room && !in_warm |=> !charge_permit_out)
    else $error("cold and hot zones must block charging");

  a_room_current_step:
    assert property (@(posedge clk_in) disable iff (reset_in)
      mon && in_room && room_iscl == 3'h6 |=>
        current_tenths_out == 4'h8)
    else $error("room zone code 110 must give 0.8 current");

endmodule

/* verification/tb_top.sv */
// self-checking bench for the thermal zone charge configuration block
// assumes the package, interface and design modules under logic/ come first
`timescale 1ns/1ps
module tb_top
  import thzc_pkg::*;
;
  // ------------------------------------------------------------------
  // stimulus and wiring
  // ------------------------------------------------------------------
  logic       clk_in   = 1'b0;
  logic       reset_in = 1'b1;
  logic       scl      = 1'b1;
  logic       sda_m    = 1'b1;
  logic       supply   = 1'b0;
  logic       option   = 1'b0;
  logic [2:0] zone     = ZONE_ROOM;
  wire        sda_out;
  wire        sda_oe;
  wire  [1:0] en_out;
  wire        mon;
  wire        permit;
  wire  [3:0] tenths;
  wire  [7:0] mv;
  wire        sda_line = sda_m & ~sda_oe;
  int         n_fail = 0;
  int         checks_done = 0;

  always #5 clk_in = ~clk_in;

  thzc_config dut_u (
    .clk_in                     (clk_in),
    .reset_in                   (reset_in),
    .i2c_scl_in                 (scl),
    .i2c_sda_in                 (sda_line),
    .i2c_sda_out                (sda_out),
    .i2c_sda_oe_out             (sda_oe),
    .charger_input_supply_in    (supply),
    .input_detect_option_in     (option),
    .zone_in                    (zone),
    .thermistor_zone_enable_out (en_out),
    .monitor_enable_out         (mon),
    .charge_permit_out          (permit),
    .current_tenths_out         (tenths),
    .voltage_reduction_mv_out   (mv)
  );

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic put_bit(input logic b);
    sda_m = b;
    tick(6);
    scl = 1'b1;
    tick(8);
    scl = 1'b0;
    tick(2);
  endtask

  task automatic get_bit(output logic b);
    sda_m = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(4);
    b = sda_line;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask

  task automatic start_cond;
    sda_m = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(6);
    sda_m = 1'b0;
    tick(6);
    scl = 1'b0;
    tick(2);
  endtask

  task automatic stop_cond;
    sda_m = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(6);
    sda_m = 1'b1;
    tick(6);
  endtask

  task automatic send_byte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(a);
    check({7'h00, a}, 8'h00, "acknowledge");
  endtask

  task automatic reg_write(input logic [7:0] ofs, input logic [7:0] d);
    start_cond();
    send_byte({DEV_ADDR, 1'b0});
    send_byte(ofs);
    send_byte(d);
    stop_cond();
  endtask

  task automatic reg_read(input logic [7:0] ofs, output logic [7:0] d);
    start_cond();
    send_byte({DEV_ADDR, 1'b0});
    send_byte(ofs);
    start_cond();
    send_byte({DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(1'b1);
    stop_cond();
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] d;
    check({6'h00, en_out}, 8'h03, "enable after reset");
    check({7'h00, sda_out}, 8'h00, "sda output level");
    reg_read(COOL_OFS, d);
    check(d, COOL_RST, "cool default");
    reg_read(ROOM_OFS, d);
    check(d, ROOM_RST, "room default");
    $display("test reset done");
  endtask

  task automatic t_enable;
    logic exp;
    for (int e = 0; e < 4; e++) begin
      reg_write(COOL_OFS, {1'b0, e[1:0], 5'h00});
      check({6'h00, en_out}, {6'h00, e[1:0]}, "enable field");
      for (int z = 0; z < 5; z++) begin
        zone = z[2:0];
        tick(3);
        case (z)
          1: exp = e[0];
          2: exp = 1'b1;
          3: exp = e[1];
          default: exp = 1'b0;
        endcase
        if (e == 0) begin
          exp = 1'b1;
        end
        check({7'h00, permit}, {7'h00, exp}, "permit");
        check({7'h00, mon}, {7'h00, e != 0}, "monitor");
      end
    end
    $display("test enable codes done");
  endtask

  task automatic t_zone(input logic [7:0] ofs, input logic [2:0] zn);
    logic [7:0] mvtab[4];
    logic [1:0] v;
    logic [2:0] top;
    mvtab = '{MV_150, MV_100, MV_50, MV_0};
    top = (ofs == COOL_OFS) ? 3'h3 : 3'h0;
    zone = zn;
    for (int c = 0; c < 8; c++) begin
      v = c[1:0] + 2'h1;
      reg_write(ofs, {top, v, c[2:0]});
      tick(3);
      check({4'h0, tenths}, (c == 7) ? 8'h0a : 8'(c + 2),
            "tenths");
      check(mv, mvtab[v], "reduction");
    end
    $display("test zone %0d scaling done", zn);
  endtask

  task automatic t_reserved;
    logic [7:0] d;
    logic [7:0] bad;
    logic       a;
    bad = {DEV_ADDR ^ 7'h01, 1'b0};
    start_cond();
    for (int i = 7; i >= 0; i--) begin
      put_bit(bad[i]);
    end
    get_bit(a);
    check({7'h00, a}, 8'h01, "no ack for other address");
    stop_cond();
    reg_write(ROOM_OFS, 8'hff);
    reg_read(ROOM_OFS, d);
    check(d, 8'h1f, "room reserved bits");
    reg_write(COOL_OFS, 8'hff);
    reg_read(COOL_OFS, d);
    check(d, 8'h7f, "cool reserved bit");
    reg_write(8'h20, 8'h5a);
    reg_read(8'h20, d);
    check(d, UNMAPPED_DATA, "unmapped offset");
    $display("test reserved and unmapped done");
  endtask

  task automatic t_supply;
    logic [7:0] d;
    option = 1'b0;
    reg_write(COOL_OFS, 8'h0a);
    reg_write(ROOM_OFS, 8'h0a);
    supply = 1'b1;
    tick(8);
    reg_read(COOL_OFS, d);
    check(d, 8'h0a, "no restore on unselected edge");
    supply = 1'b0;
    tick(8);
    reg_read(COOL_OFS, d);
    check(d, COOL_RST, "cool restored on falling");
    reg_read(ROOM_OFS, d);
    check(d, ROOM_RST, "room restored on falling");
    option = 1'b1;
    reg_write(COOL_OFS, 8'h0a);
    reg_write(ROOM_OFS, 8'h0a);
    supply = 1'b1;
    tick(8);
    reg_read(COOL_OFS, d);
    check(d, COOL_RST, "cool restored on rising");
    reg_read(ROOM_OFS, d);
    check(d, ROOM_RST, "room restored on rising");
    $display("test supply edge done");
  endtask

  // ------------------------------------------------------------------
  // main sequence and hang guard
  // ------------------------------------------------------------------
  initial begin
    tick(2);
    reset_in = 1'b0;
    tick(4);
    t_reset();
    t_enable();
    t_zone(COOL_OFS, ZONE_COOL);
    t_zone(ROOM_OFS, ZONE_ROOM);
    t_reserved();
    t_supply();
    end_of_test();
  end

  initial begin
    repeat (100000) @(posedge clk_in);
    n_fail++;
    $display("unexpected at %0t: run did not finish", $time);
    end_of_test();
  end
endmodule
